/* src/capture_input_pkg.sv */
// constants and types shared by the capture input configuration block
`default_nettype none
package capture_input_pkg;

  localparam int unsigned REG_W         = 16;
  localparam int unsigned CNT_W         = 16;

  // register byte addresses
  localparam logic [7:0] ADDR_CH34_CFG  = 8'h1c;
  localparam logic [7:0] ADDR_ENA_POL   = 8'h20;

  // reset values
  localparam logic [15:0] RST_CH34_CFG  = 16'h0000;
  localparam logic [15:0] RST_ENA_POL   = 16'h0000;

  // channel34_input_config field positions
  localparam int unsigned CH3_SEL_LSB   = 0;
  localparam int unsigned CH3_PSC_LSB   = 2;
  localparam int unsigned CH3_FLT_LSB   = 4;
  localparam int unsigned CH4_SEL_LSB   = 8;
  localparam int unsigned CH4_PSC_LSB   = 10;
  localparam int unsigned CH4_FLT_LSB   = 12;

  // channel_enable_polarity bit positions
  localparam int unsigned CH1_EN_BIT    = 0;
  localparam int unsigned CH1_POL_BIT   = 1;
  localparam int unsigned CH1_NPOL_BIT  = 3;
  localparam int unsigned CH3_EN_BIT    = 8;
  localparam int unsigned CH3_POL_BIT   = 9;
  localparam int unsigned CH3_NPOL_BIT  = 11;
  localparam int unsigned CH4_EN_BIT    = 12;
  localparam int unsigned CH4_POL_BIT   = 13;
  localparam int unsigned CH4_NPOL_BIT  = 15;

  // synchroniser lanes
  localparam int unsigned SYN_TI3       = 0;
  localparam int unsigned SYN_TI4       = 1;
  localparam int unsigned SYN_TI1       = 2;

  // direction field codes
  typedef enum logic [1:0] {
    DIR_OUTPUT  = 2'b00,
    DIR_OWN_PIN = 2'b01,
    DIR_ALT_PIN = 2'b10,
    DIR_TRIGGER = 2'b11
  } dir_e;

  // prescaler limits for codes 00..11 (events per capture minus one)
  localparam logic [2:0] PSC_LIM_1      = 3'h0;
  localparam logic [2:0] PSC_LIM_2      = 3'h1;
  localparam logic [2:0] PSC_LIM_4      = 3'h3;
  localparam logic [2:0] PSC_LIM_8      = 3'h7;

endpackage
`default_nettype wire

/* src/timer_capture_input_config.sv */
// capture input configuration, channel enables and polarity for a timer
`default_nettype none
module timer_capture_input_config
  import capture_input_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [7:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr_strobe,
  input  wire logic              rd_strobe,
  output var  logic [15:0]       rdata,
  input  wire logic              timer_input_three,
  input  wire logic              timer_input_four,
  input  wire logic              filtered_input_edge,
  input  wire logic              internal_trigger_source,
  input  wire logic [CNT_W-1:0]  counter_value,
  input  wire logic              ch1_is_input,
  input  wire logic              ch1_compare_ref,
  output var  logic              ch1_compare_output,
  output var  logic              ch1_output_enable,
  output var  logic [CNT_W-1:0]  ch1_capture_value,
  output var  logic              ch1_capture_pulse,
  output var  logic              ch3_capture_signal,
  output var  logic              ch4_capture_signal,
  output var  logic              ch1_level,
  output var  logic              ch3_level,
  output var  logic              ch4_level
);

  typedef struct packed {
    logic [15:0]      cfg;
    logic [15:0]      enp;
    logic [15:0]      rdata;
    logic [2:0]       sync_a;
    logic [2:0]       sync_b;
    logic [3:0]       f3_cnt;
    logic [3:0]       f4_cnt;
    logic             f3;
    logic             f4;
    logic [2:0]       pc3;
    logic [2:0]       pc4;
    logic             cap1;
    logic             cap3;
    logic             cap4;
    logic [CNT_W-1:0] cap1_val;
    logic             oc1;
    logic             oe1;
    logic             lv1;
    logic             lv3;
    logic             lv4;
  } state_s;

  state_s st_q;
  state_s st_d;

  // filter: a change is taken once it has held for code samples
  function automatic logic [4:0] filt(input logic       raw,
                                      input logic       cur,
                                      input logic [3:0] cnt,
                                      input logic [3:0] code);
    logic [3:0] nxt;
    nxt = cnt + 4'h1;
    if (code == 4'h0) begin
      filt = {raw, 4'h0};
    end else if (raw == cur) begin
      filt = {cur, 4'h0};
    end else if (nxt >= code) begin
      filt = {raw, 4'h0};
    end else begin
      filt = {cur, nxt};
    end
  endfunction

  function automatic logic polar(input logic lvl,
                                 input logic pol,
                                 input logic npol);
    polar = lvl ^ (pol & ~npol);
  endfunction

  // both edges only for combination 11; reserved 10 acts like 00
  function automatic logic edge_ev(input logic cur,
                                   input logic prev,
                                   input logic pol,
                                   input logic npol);
    if (pol & npol) begin
      edge_ev = cur ^ prev;
    end else begin
      edge_ev = cur & ~prev;
    end
  endfunction

  function automatic logic src_mux(input logic [1:0] sel,
                                   input logic       own,
                                   input logic       alt,
                                   input logic       trg);
    case (dir_e'(sel))
      DIR_OWN_PIN: src_mux = own;
      DIR_ALT_PIN: src_mux = alt;
      DIR_TRIGGER: src_mux = trg;
      default:     src_mux = 1'b0;
    endcase
  endfunction

  // returns {capture, next count}
  function automatic logic [3:0] psc_step(input logic       ev,
                                          input logic [2:0] cnt,
                                          input logic [1:0] code);
    logic [2:0] lim;
    case (code)
      2'b00:   lim = PSC_LIM_1;
      2'b01:   lim = PSC_LIM_2;
      2'b10:   lim = PSC_LIM_4;
      default: lim = PSC_LIM_8;
    endcase
    if (!ev) begin
      psc_step = {1'b0, cnt};
    end else if (cnt >= lim) begin
      psc_step = {1'b1, 3'h0};
    end else begin
      psc_step = {1'b0, cnt + 3'h1};
    end
  endfunction

  logic [1:0] sel3;
  logic [1:0] sel4;
  logic       en1;
  logic       en3;
  logic       en4;
  assign sel3 = st_q.cfg[CH3_SEL_LSB +: 2];
  assign sel4 = st_q.cfg[CH4_SEL_LSB +: 2];
  assign en1  = st_q.enp[CH1_EN_BIT];
  assign en3  = st_q.enp[CH3_EN_BIT];
  assign en4  = st_q.enp[CH4_EN_BIT];

  logic [4:0] fr3;
  logic [4:0] fr4;
  logic [3:0] pr3;
  logic [3:0] pr4;
  logic       raw3;
  logic       raw4;
  logic       pl1;
  logic       pl3;
  logic       pl4;
  logic       ev1;
  logic       ev3;
  logic       ev4;
  always_comb begin
    st_d = st_q;
    // second stage is the only reader of the first
    st_d.sync_a = {filtered_input_edge, timer_input_four, timer_input_three};
    st_d.sync_b = st_q.sync_a;

    // register writes
    if (wr_strobe) begin
      if (addr == ADDR_CH34_CFG) begin
        st_d.cfg = wdata;
        if (en3) begin
          st_d.cfg[CH3_SEL_LSB +: 2] = sel3;
        end
        if (en4) begin
          st_d.cfg[CH4_SEL_LSB +: 2] = sel4;
        end
      end else if (addr == ADDR_ENA_POL) begin
        st_d.enp = wdata;
      end
    end

    // read data stands only in the cycle after the strobe
    st_d.rdata = 16'h0000;
    if (rd_strobe) begin
      if (addr == ADDR_CH34_CFG) begin
        st_d.rdata = st_q.cfg;
      end else if (addr == ADDR_ENA_POL) begin
        st_d.rdata = st_q.enp;
      end
    end

    fr3 = filt(st_q.sync_b[SYN_TI3], st_q.f3, st_q.f3_cnt,
               st_q.cfg[CH3_FLT_LSB +: 4]);
    fr4 = filt(st_q.sync_b[SYN_TI4], st_q.f4, st_q.f4_cnt,
               st_q.cfg[CH4_FLT_LSB +: 4]);
    st_d.f3     = fr3[4];
    st_d.f3_cnt = fr3[3:0];
    st_d.f4     = fr4[4];
    st_d.f4_cnt = fr4[3:0];

    raw3 = src_mux(sel3, st_q.f3, st_q.f4, internal_trigger_source);
    raw4 = src_mux(sel4, st_q.f4, st_q.f3, internal_trigger_source);

    pl1 = polar(st_q.sync_b[SYN_TI1], st_q.enp[CH1_POL_BIT],
                st_q.enp[CH1_NPOL_BIT]);
    pl3 = polar(raw3, st_q.enp[CH3_POL_BIT], st_q.enp[CH3_NPOL_BIT]);
    pl4 = polar(raw4, st_q.enp[CH4_POL_BIT], st_q.enp[CH4_NPOL_BIT]);
    st_d.lv1 = pl1;
    st_d.lv3 = pl3;
    st_d.lv4 = pl4;

    ev1 = edge_ev(pl1, st_q.lv1, st_q.enp[CH1_POL_BIT],
                  st_q.enp[CH1_NPOL_BIT]);
    ev3 = edge_ev(pl3, st_q.lv3, st_q.enp[CH3_POL_BIT],
                  st_q.enp[CH3_NPOL_BIT]);
    ev4 = edge_ev(pl4, st_q.lv4, st_q.enp[CH4_POL_BIT],
                  st_q.enp[CH4_NPOL_BIT]);

    // ch3 and ch4 prescalers; each held in reset while its channel is off or set to output
    pr3 = psc_step(ev3, st_q.pc3, st_q.cfg[CH3_PSC_LSB +: 2]);
    pr4 = psc_step(ev4, st_q.pc4, st_q.cfg[CH4_PSC_LSB +: 2]);
    if (en3 && (sel3 != DIR_OUTPUT)) begin
      st_d.pc3  = pr3[2:0];
      st_d.cap3 = pr3[3];
    end else begin
      st_d.pc3  = 3'h0;
      st_d.cap3 = 1'b0;
    end
    if (en4 && (sel4 != DIR_OUTPUT)) begin
      st_d.pc4  = pr4[2:0];
      st_d.cap4 = pr4[3];
    end else begin
      st_d.pc4  = 3'h0;
      st_d.cap4 = 1'b0;
    end

    // ch1 counter capture gated by enable
    st_d.cap1 = ch1_is_input && en1 && ev1;
    if (st_d.cap1) begin
      st_d.cap1_val = counter_value;
    end

    // ch1 output drive gated by enable
    st_d.oe1 = !ch1_is_input && en1;
    // ch1 output polarity; idles low when not driven
    st_d.oc1 = st_d.oe1 && (ch1_compare_ref ^ st_q.enp[CH1_POL_BIT]);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q          <= '0;
      st_q.cfg      <= RST_CH34_CFG;
      st_q.enp      <= RST_ENA_POL;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata              = st_q.rdata;
  assign ch1_compare_output = st_q.oc1;
  assign ch1_output_enable  = st_q.oe1;
  assign ch1_capture_value  = st_q.cap1_val;
  assign ch1_capture_pulse  = st_q.cap1;
  assign ch3_capture_signal = st_q.cap3;
  assign ch4_capture_signal = st_q.cap4;
  assign ch1_level          = st_q.lv1;
  assign ch3_level          = st_q.lv3;
  assign ch4_level          = st_q.lv4;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic cfg_wr;
  assign cfg_wr = wr_strobe && (addr == ADDR_CH34_CFG);

  // ch3 output direction never captures
  ch3_out_nocap_a: assert property (
    ch3_capture_signal |-> $past(sel3 != DIR_OUTPUT) && $past(en3))
    else $error("ch3 captured while output or disabled");

  ch3_dir_lock_a: assert property (
    cfg_wr && en3 |=> sel3 == $past(sel3))
    else $error("ch3 direction changed while enabled");

  ch3_dir_open_a: assert property (
    cfg_wr && !en3 |=> sel3 == $past(wdata[CH3_SEL_LSB +: 2]))
    else $error("ch3 direction write lost while disabled");

  ch4_dir_lock_a: assert property (
    cfg_wr && en4 |=> sel4 == $past(sel4))
    else $error("ch4 direction changed while enabled");

  ch3_psc_range_a: assert property (
    st_q.cfg[CH3_PSC_LSB +: 2] == 2'b01 && !cfg_wr |=> st_q.pc3 <= 3'h1)
    else $error("ch3 prescale count above limit");

  ch3_psc_one_a: assert property (
    st_q.cfg[CH3_PSC_LSB +: 2] == 2'b00 && $stable(st_q.cfg) &&
    sel3 == DIR_TRIGGER && en3 && st_q.enp[CH3_NPOL_BIT +: 1] == 1'b0 &&
    !st_q.enp[CH3_POL_BIT] && $stable(st_q.enp) &&
    $rose(internal_trigger_source) |=> ch3_capture_signal)
    else $error("ch3 missed rising trigger edge");

  ch4_fall_cap_a: assert property (
    st_q.cfg[CH4_PSC_LSB +: 2] == 2'b00 && $stable(st_q.cfg) &&
    sel4 == DIR_TRIGGER && en4 && !st_q.enp[CH4_NPOL_BIT] &&
    st_q.enp[CH4_POL_BIT] && $stable(st_q.enp) &&
    $fell(internal_trigger_source) |=> ch4_capture_signal)
    else $error("ch4 missed falling trigger edge");

  ch4_src_trig_a: assert property (
    sel4 == DIR_TRIGGER |=>
    ch4_level == ($past(internal_trigger_source) ^
                  ($past(st_q.enp[CH4_POL_BIT]) &
                   ~$past(st_q.enp[CH4_NPOL_BIT]))))
    else $error("ch4 level not from trigger");

  ch3_both_edge_a: assert property (
    st_q.cfg[CH3_PSC_LSB +: 2] == 2'b00 && $stable(st_q.cfg) &&
    sel3 == DIR_TRIGGER && en3 && st_q.enp[CH3_NPOL_BIT] &&
    st_q.enp[CH3_POL_BIT] && $stable(st_q.enp) &&
    $fell(internal_trigger_source) |=> ch3_capture_signal)
    else $error("ch3 missed falling edge in both-edge mode");

  ch3_level_pol_a: assert property (
    sel3 == DIR_TRIGGER && !st_q.enp[CH3_POL_BIT] |=>
    ch3_level == $past(internal_trigger_source))
    else $error("ch3 level inverted under polarity 00");

  ch1_drive_a: assert property (
    ch1_output_enable |-> $past(en1) && !$past(ch1_is_input))
    else $error("ch1 driven while disabled");

  ch1_off_low_a: assert property (
    !en1 |=> !ch1_output_enable ##0 !ch1_compare_output)
    else $error("ch1 output not disabled");

  ch1_polarity_a: assert property (
    ch1_output_enable |->
    ch1_compare_output == ($past(ch1_compare_ref) ^
                           $past(st_q.enp[CH1_POL_BIT])))
    else $error("ch1 output polarity wrong");

  ch1_cap_gate_a: assert property (
    ch1_capture_pulse |-> $past(en1) && $past(ch1_is_input) &&
    ch1_capture_value == $past(counter_value))
    else $error("ch1 capture without enable or wrong value");

  ch3_filt_pass_a: assert property (
    st_q.cfg[CH3_FLT_LSB +: 4] == 4'h0 |=>
    st_q.f3 == $past(st_q.sync_b[SYN_TI3]))
    else $error("ch3 unfiltered input not passed");

  ch3_cap_c: cover property (ch3_capture_signal);
  ch4_cap_c: cover property (ch4_capture_signal);
  ch1_cap_c: cover property (ch1_capture_pulse);
  lock_hit_c: cover property (cfg_wr && en3);

endmodule
`default_nettype wire

/* tb/timer_pin_model.sv */
// partner model: timer input pins, ch1 input and internal trigger
`default_nettype none
module timer_pin_model (
  input  wire logic clk,
  output var  logic timer_input_three,
  output var  logic timer_input_four,
  output var  logic filtered_input_edge,
  output var  logic internal_trigger_source
);
  timeunit 1ns;
  timeprecision 1ps;

  // lanes: 0 input three, 1 input four, 2 ch1 input, 3 trigger
  logic [3:0] pins_q = 4'h0;

  assign timer_input_three       = pins_q[0];
  assign timer_input_four        = pins_q[1];
  assign filtered_input_edge     = pins_q[2];
  assign internal_trigger_source = pins_q[3];

  // moves just after an edge: the trigger lane is same-clock, no sync
  task automatic drive(input logic [3:0] mask, input logic val,
                       input int hold);
    @(posedge clk);
    pins_q <= val ? (pins_q | mask) : (pins_q & ~mask);
    repeat (hold) @(posedge clk);
  endtask

  // idle low afterwards, so no stale level is left for the edge history
  task automatic pulse(input logic [3:0] mask, input int width);
    drive(mask, 1'b1, width);
    drive(mask, 1'b0, 8);
  endtask
endmodule
`default_nettype wire

/* tb/timer_capture_input_config_tb_top.sv */
// self-checking bench for the capture input configuration block
`default_nettype none
module timer_capture_input_config_tb_top
  import capture_input_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic [7:0]       addr = 8'h00;
  logic [15:0]      wdata = 16'h0000;
  logic             wr_strobe = 1'b0;
  logic             rd_strobe = 1'b0;
  logic [CNT_W-1:0] counter_value = 16'h0000;
  logic             ch1_is_input = 1'b0;
  logic             ch1_compare_ref = 1'b0;
  wire logic        ti3, ti4, tfe, trg;
  logic [15:0]      rdata;
  logic [CNT_W-1:0] cap_val;
  logic             cmp_out, oe, cap1, cap3, cap4, lvl1, lvl3, lvl4;
  int               err_count = 0;
  int               n_compared = 0;
  int               n1 = 0, n3 = 0, n4 = 0, b1, b3, b4;

  always #12.5 clk = ~clk;

  timer_pin_model timer_pin_model_inst (
    .clk(clk), .timer_input_three(ti3), .timer_input_four(ti4),
    .filtered_input_edge(tfe), .internal_trigger_source(trg));

  timer_capture_input_config timer_capture_input_config_inst (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
    .timer_input_three(ti3), .timer_input_four(ti4),
    .filtered_input_edge(tfe), .internal_trigger_source(trg),
    .counter_value(counter_value), .ch1_is_input(ch1_is_input),
    .ch1_compare_ref(ch1_compare_ref), .ch1_compare_output(cmp_out),
    .ch1_output_enable(oe), .ch1_capture_value(cap_val),
    .ch1_capture_pulse(cap1), .ch3_capture_signal(cap3),
    .ch4_capture_signal(cap4), .ch1_level(lvl1), .ch3_level(lvl3),
    .ch4_level(lvl4));

  // pulses are counted, tests compare against a snapshot
  always @(posedge clk) begin
    if (cap1 === 1'b1) n1 <= n1 + 1;
    if (cap3 === 1'b1) n3 <= n3 + 1;
    if (cap4 === 1'b1) n4 <= n4 + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 check(rdata, exp);
    @(posedge clk);
    // read data must fall back to zero once its cycle is over
    @(negedge clk);
    check(rdata, 16'h0000);
    @(posedge clk);
  endtask

  // each direction field only moves while its own channel is off
  task automatic setup(input logic [15:0] cfg, input logic [15:0] ena);
    wr(ADDR_ENA_POL, 16'h0000);
    wr(ADDR_CH34_CFG, cfg);
    wr(ADDR_ENA_POL, ena);
    repeat (8) @(posedge clk);
    b1 = n1;
    b3 = n3;
    b4 = n4;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    logic e3, e4;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk(ADDR_CH34_CFG, RST_CH34_CFG);
    rd_chk(ADDR_ENA_POL, RST_ENA_POL);
    rd_chk(8'h00, 16'h0000);
    wr(ADDR_CH34_CFG, 16'hffff);
    rd_chk(ADDR_CH34_CFG, 16'hffff);
    wr(ADDR_ENA_POL, 16'h1100);
    wr(ADDR_CH34_CFG, 16'h0000);
    rd_chk(ADDR_CH34_CFG, 16'h0303);
    wr(ADDR_ENA_POL, 16'h1000);
    wr(ADDR_CH34_CFG, 16'h0000);
    rd_chk(ADDR_CH34_CFG, 16'h0300);
    wr(8'h40, 16'h5555);
    rd_chk(ADDR_CH34_CFG, 16'h0300);
    rd_chk(ADDR_ENA_POL, 16'h1000);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 3; p++) begin
        setup(16'(s) | (16'(s) << 8), 16'h1100);
        timer_pin_model_inst.pulse(p == 2 ? 4'b1000 : 4'b0001 << p, 1);
        e3 = (s == 1 && p == 0) || (s == 2 && p == 1) || (s == 3 && p == 2);
        e4 = (s == 1 && p == 1) || (s == 2 && p == 0) || (s == 3 && p == 2);
        check(16'(n3 - b3), {15'h0, e3});
        check(16'(n4 - b4), {15'h0, e4});
      end
    end
    $display("test routing done");
    for (int p = 0; p < 4; p++) begin
      setup(16'h0101 | (16'(p) << 2) | (16'(p) << 10), 16'h1100);
      repeat (8) timer_pin_model_inst.pulse(4'b0011, 1);
      check(16'(n3 - b3), 16'(8 >> p));
      check(16'(n4 - b4), 16'(8 >> p));
    end
    setup(16'h0141, 16'h1100);
    timer_pin_model_inst.pulse(4'b0011, 1);
    timer_pin_model_inst.pulse(4'b0011, 10);
    check(16'(n3 - b3), 16'h0001);
    check(16'(n4 - b4), 16'h0002);
    $display("test prescale and filter done");
    // combination 10 stays unused by software
    for (int c = 0; c < 4; c++) begin
      if (c == 2) continue;
      // same polarity pair on ch1, ch3 and ch4
      setup(16'h0101, 16'h1100 | (16'(c & 1) * 16'h2202) |
            (16'(c >> 1) * 16'h8808));
      check(lvl3, c == 1);
      check(lvl4, c == 1);
      check(lvl1, c == 1);
      timer_pin_model_inst.drive(4'b0111, 1'b1, 8);
      check(16'(n3 - b3), 16'(c != 1));
      check(16'(n4 - b4), 16'(c != 1));
      check(lvl1, c != 1);
      check(lvl4, c != 1);
      timer_pin_model_inst.drive(4'b0111, 1'b0, 8);
      check(16'(n3 - b3), c == 3 ? 16'h0002 : 16'h0001);
      check(16'(n4 - b4), c == 3 ? 16'h0002 : 16'h0001);
      check(lvl3, c == 1);
      check(lvl1, c == 1);
    end
    $display("test polarity done");
    for (int k = 0; k < 4; k++) begin
      ch1_compare_ref <= k[0];
      wr(ADDR_ENA_POL, 16'(k[1]) << 1);
      repeat (2) @(posedge clk);
      check(oe, 1'b0);
      check(cmp_out, 1'b0);
      wr(ADDR_ENA_POL, 16'h0001 | (16'(k[1]) << 1));
      repeat (2) @(posedge clk);
      check(oe, 1'b1);
      check(cmp_out, k[0] ^ k[1]);
    end
    ch1_is_input <= 1'b1;
    repeat (2) @(posedge clk);
    check(oe, 1'b0);
    $display("test ch1 output done");
    counter_value <= 16'h1234;
    setup(16'h0000, 16'h0000);
    timer_pin_model_inst.pulse(4'b0100, 2);
    check(16'(n1 - b1), 16'h0000);
    check(cap_val, 16'h0000);
    setup(16'h0000, 16'h0001);
    timer_pin_model_inst.pulse(4'b0100, 2);
    check(16'(n1 - b1), 16'h0001);
    check(cap_val, 16'h1234);
    counter_value <= 16'hbeef;
    timer_pin_model_inst.pulse(4'b0100, 2);
    check(cap_val, 16'hbeef);
    $display("test ch1 capture done");
    end_of_test();
  end
endmodule
`default_nettype wire
